// *** hw/strap_osc_pkg.sv ***
// shared constants and carrier types for strap decode and oscillator front end
package strap_osc_pkg;
    // widths
    localparam int IDX_W = 3;
    localparam int MODE_W = 2;
    localparam int ADDR_W = 7;
    localparam int CAP_W = 5;
    // interface-mode strap codes
    localparam logic [MODE_W-1:0] IF_I2C_A = 2'h0;
    localparam logic [MODE_W-1:0] IF_I2C_B = 2'h1;
    localparam logic [MODE_W-1:0] IF_I2C_C = 2'h2;
    localparam logic [MODE_W-1:0] IF_SPI = 2'h3;
    // default slave addresses per strap code, and the address register reset value
    localparam logic [ADDR_W-1:0] ADDR_A = 7'h74;
    localparam logic [ADDR_W-1:0] ADDR_B = 7'h75;
    localparam logic [ADDR_W-1:0] ADDR_C = 7'h76;
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    // config index that, with the test strap, skips auto-configuration
    localparam logic [IDX_W-1:0] IDX_NO_AUTOCFG = 3'h3;
    // oscillator pin buffer mode codes
    localparam logic [MODE_W-1:0] BUF_XTAL = 2'h1;
    localparam logic [MODE_W-1:0] BUF_SE_IN = 2'h2;
    // load capacitance that adds no internal load
    localparam logic [CAP_W-1:0] CAP_NONE = 5'h00;

    // latched reset straps
    typedef struct packed {
        logic test;
        logic [IDX_W-1:0] cfg_index;
        logic [MODE_W-1:0] if_mode;
    } strap_t;

    localparam int STRAP_W = $bits(strap_t);
    localparam logic [STRAP_W-1:0] STRAP_RST = 6'h00;

    // oscillator front end controls
    typedef struct packed {
        logic xtal_drv_en;
        logic se_in_en;
        logic [CAP_W-1:0] pin_a_cap;
        logic [CAP_W-1:0] pin_b_cap;
        logic osc_x2;
        logic pll_in_x2;
    } osc_ctrl_t;

    localparam int OSC_W = $bits(osc_ctrl_t);
    localparam logic [OSC_W-1:0] OSC_RST = 14'h0000;
endpackage

// *** hw/load_hold_reg.sv ***
// register that loads a word when enabled and holds it otherwise
`timescale 1ns/10ps
module load_hold_reg #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk_i, // core clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic load_i, // take d_i this edge
    input wire logic [W-1:0] d_i, // word to load
    output logic [W-1:0] q_o // held word
);
    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    // next value: load or hold
    always_comb
    begin
        val_d = load_i ? d_i : val_q;
    end

    // storage
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            val_q <= RST;
        end
        else
        begin
            val_q <= val_d;
        end
    end

    assign q_o = val_q;
endmodule

// *** hw/strap_osc_ctrl.sv ***
// reset strap decode, slave address register and oscillator front end control
// Operation
// - interface straps 00/01/10 pick I2C address 74/75/76, 11 picks SPI slave
// - config-select straps index stored configuration 0 to 7
// - strap address is only the default; host may overwrite slave address
// - auto-configuration script may also write the slave address register
// - buffer mode 10 enables pin A single-ended clock input
// - buffer mode 01 enables crystal driver between both pins
// - separate load cap fields per pin; zero adds no internal load
// - oscillator doubler enable doubles crystal or pin A clock
// - pll input doubler enable doubles the selected pll input
// - straps sampled at reset release, held as read-only status
// - test strap with index 011 skips auto-configuration
`timescale 1ns/10ps
module strap_osc_ctrl (
    input wire logic core_clk_i, // core clock, 25 MHz
    input wire logic rst_n_i, // reset pin, async, active low
    input wire logic test_strap_i, // test strap level
    input wire logic [2:0] config_index_strap_i, // configuration select straps
    input wire logic [1:0] if_mode_strap_i, // interface mode straps
    input wire logic script_addr_wr_i, // auto-config write strobe
    input wire logic [6:0] script_addr_i, // auto-config address data
    input wire logic host_addr_wr_i, // host write strobe
    input wire logic [6:0] host_addr_i, // host address data
    input wire logic [1:0] osc_pin_buffer_mode_i, // pin buffer mode field
    input wire logic [4:0] pin_a_load_cap_i, // pin A load cap field
    input wire logic [4:0] pin_b_load_cap_i, // pin B load cap field
    input wire logic osc_doubler_enable_i, // oscillator doubler enable
    input wire logic pll_input_doubler_enable_i, // pll input doubler enable
    output strap_osc_pkg::strap_t strap_status_reg_o, // latched straps, read only
    output logic straps_valid_o, // straps have been latched
    output logic spi_mode_o, // spi slave selected
    output logic [6:0] slave_address_reg_o, // current i2c slave address
    output logic [2:0] config_index_o, // configuration to run
    output logic autocfg_run_o, // auto-configuration permitted
    output strap_osc_pkg::osc_ctrl_t osc_ctrl_o // oscillator front end controls
);
    logic captured_q;
    logic captured_d;
    strap_osc_pkg::strap_t strap_now;
    strap_osc_pkg::strap_t strap_q;
    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic [6:0] addr_dflt;
    strap_osc_pkg::osc_ctrl_t osc_d;
    strap_osc_pkg::osc_ctrl_t osc_q;

    // first edge after release catches the straps; an async reset cannot load a port
    always_comb
    begin
        captured_d = 1'b1;
        strap_now.test = test_strap_i;
        strap_now.cfg_index = config_index_strap_i;
        strap_now.if_mode = if_mode_strap_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            captured_q <= 1'b0;
        end
        else
        begin
            captured_q <= captured_d;
        end
    end

    // status register frozen after the capture edge
    load_hold_reg #(
        .W(strap_osc_pkg::STRAP_W),
        .RST(strap_osc_pkg::STRAP_RST)
    ) u_strap_hold (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(!captured_q),
        .d_i(strap_now),
        .q_o(strap_q)
    );

    // address default from the interface straps
    always_comb
    begin
        unique case (strap_now.if_mode)
            strap_osc_pkg::IF_I2C_A: addr_dflt = strap_osc_pkg::ADDR_A;
            strap_osc_pkg::IF_I2C_B: addr_dflt = strap_osc_pkg::ADDR_B;
            strap_osc_pkg::IF_I2C_C: addr_dflt = strap_osc_pkg::ADDR_C;
            strap_osc_pkg::IF_SPI: addr_dflt = strap_osc_pkg::ADDR_C;
        endcase
    end

    // slave address: strap default once, then script or host writes
    always_comb
    begin
        addr_d = addr_q;
        if (!captured_q)
        begin
            addr_d = addr_dflt;
        end
        else if (script_addr_wr_i)
        begin
            addr_d = script_addr_i;
        end
        else if (host_addr_wr_i)
        begin
            addr_d = host_addr_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_q <= strap_osc_pkg::ADDR_RST;
        end
        else
        begin
            addr_q <= addr_d;
        end
    end

    // oscillator front end; unknown buffer codes leave both paths off
    always_comb
    begin
        osc_d.xtal_drv_en = (osc_pin_buffer_mode_i == strap_osc_pkg::BUF_XTAL);
        osc_d.se_in_en = (osc_pin_buffer_mode_i == strap_osc_pkg::BUF_SE_IN);
        // fields pass straight through so zero really means no internal load
        osc_d.pin_a_cap = pin_a_load_cap_i;
        osc_d.pin_b_cap = pin_b_load_cap_i;
        // doubler only meaningful with a live oscillator path
        osc_d.osc_x2 = osc_doubler_enable_i
            && (osc_d.xtal_drv_en || osc_d.se_in_en);
        // chaining both doublers is software's duty to avoid; not blocked here
        osc_d.pll_in_x2 = pll_input_doubler_enable_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            osc_q <= strap_osc_pkg::OSC_RST;
        end
        else
        begin
            osc_q <= osc_d;
        end
    end

    // outputs
    assign strap_status_reg_o = strap_q;
    assign straps_valid_o = captured_q;
    assign spi_mode_o = captured_q && (strap_q.if_mode == strap_osc_pkg::IF_SPI);
    assign slave_address_reg_o = addr_q;
    assign config_index_o = strap_q.cfg_index;
    assign autocfg_run_o = captured_q
        && !(strap_q.test && strap_q.cfg_index == strap_osc_pkg::IDX_NO_AUTOCFG);
    assign osc_ctrl_o = osc_q;

    // status holds once latched
    strap_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        captured_q |=> $stable(strap_q))
        else $error("strap status changed after capture");

    // capture edge stores pin levels
    strap_take_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !captured_q |=> strap_q == $past(strap_now))
        else $error("strap levels not captured");

    // default address follows straps
    addr_default_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (!captured_q && strap_now.if_mode == strap_osc_pkg::IF_I2C_B)
        |=> addr_q == strap_osc_pkg::ADDR_B)
        else $error("wrong default slave address");

    // host write lands next cycle
    host_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (captured_q && host_addr_wr_i && !script_addr_wr_i)
        |=> addr_q == $past(host_addr_i))
        else $error("host address write lost");

    // script write lands next cycle
    script_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (captured_q && script_addr_wr_i) |=> addr_q == $past(script_addr_i))
        else $error("script address write lost");

    // spi flag follows the interface pins seen at the capture edge
    spi_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !captured_q
        |=> spi_mode_o == ($past(if_mode_strap_i) == strap_osc_pkg::IF_SPI))
        else $error("spi mode decode wrong");

    // index follows the select pins seen at the capture edge
    cfg_index_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !captured_q |=> config_index_o == $past(config_index_strap_i))
        else $error("configuration index wrong");

    // skip combination on the pins stops auto-configuration
    autocfg_skip_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (!captured_q && test_strap_i
            && config_index_strap_i == strap_osc_pkg::IDX_NO_AUTOCFG)
        |=> !autocfg_run_o)
        else $error("auto-configuration not skipped");

    // crystal mode enables driver only
    xtal_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        osc_pin_buffer_mode_i == strap_osc_pkg::BUF_XTAL
        |=> osc_q.xtal_drv_en && !osc_q.se_in_en)
        else $error("crystal driver mode wrong");

    // single-ended mode enables input only
    se_mode_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        osc_pin_buffer_mode_i == strap_osc_pkg::BUF_SE_IN
        |=> osc_q.se_in_en && !osc_q.xtal_drv_en)
        else $error("single-ended input mode wrong");

    // other codes leave both off
    buf_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (osc_pin_buffer_mode_i == 2'h0 || osc_pin_buffer_mode_i == 2'h3)
        |=> !osc_q.se_in_en && !osc_q.xtal_drv_en && !osc_q.osc_x2)
        else $error("unused buffer code enabled a path");

    // zero cap passes as zero
    cap_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pin_a_load_cap_i == strap_osc_pkg::CAP_NONE
        |=> osc_q.pin_a_cap == strap_osc_pkg::CAP_NONE)
        else $error("zero load cap not honoured");

    // pll doubler follows its enable
    pll_x2_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ##1 osc_q.pll_in_x2 == $past(pll_input_doubler_enable_i))
        else $error("pll input doubler mismatch");

    // oscillator doubler with live path
    osc_x2_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (osc_doubler_enable_i && osc_pin_buffer_mode_i == strap_osc_pkg::BUF_XTAL)
        |=> osc_q.osc_x2)
        else $error("oscillator doubler not enabled");
endmodule

// *** tb/host_cfg_model.sv ***
// host processor model: writes the slave address and the oscillator fields
`timescale 1ns/10ps
module host_cfg_model (
    input wire logic core_clk_i, // core clock
    output logic host_addr_wr_o, // address write strobe
    output logic [6:0] host_addr_o, // address data
    output logic [1:0] buf_mode_o, // pin buffer mode field
    output logic [4:0] cap_a_o, // pin A load cap
    output logic [4:0] cap_b_o, // pin B load cap
    output logic osc_dbl_o, // oscillator doubler enable
    output logic pll_dbl_o // pll input doubler enable
);
    // idle values at time zero
    initial
    begin
        host_addr_wr_o = 1'b0;
        host_addr_o = 7'h00;
        buf_mode_o = 2'h0;
        cap_a_o = 5'h00;
        cap_b_o = 5'h00;
        osc_dbl_o = 1'b0;
        pll_dbl_o = 1'b0;
    end
    // one-cycle strobe, held across the sampling edge, data scrambled after
    task automatic write_addr(input logic [6:0] a);
        host_addr_o = a;
        host_addr_wr_o = 1'b1;
        @(negedge core_clk_i);
        host_addr_wr_o = 1'b0;
        host_addr_o = ~a;
    endtask
    // the pll doubler is dropped whenever the oscillator doubler is on
    // the doubled signal is never routed to outputs from here
    task automatic set_osc(input logic [1:0] m, input logic [4:0] ca, input logic [4:0] cb,
                           input logic d, input logic p);
        buf_mode_o = m;
        cap_a_o = ca;
        cap_b_o = cb;
        osc_dbl_o = d;
        pll_dbl_o = p & ~d;
    endtask
endmodule

// *** tb/test_strap_osc_ctrl.sv ***
// testbench for strap decode, slave address and oscillator front end control
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_strap_osc_ctrl;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic test_strap = 1'b0;
    logic [2:0] idx_strap = 3'h0;
    logic [1:0] if_strap = 2'h0;
    logic script_wr = 1'b0;
    logic [6:0] script_addr = 7'h00;
    logic host_wr, osc_dbl, pll_dbl;
    logic [6:0] host_addr, addr;
    logic [1:0] buf_mode;
    logic [4:0] cap_a, cap_b;
    logic valid, spi, autocfg;
    logic [2:0] cfg_idx;
    strap_osc_pkg::strap_t status, exp_s;
    strap_osc_pkg::osc_ctrl_t osc, exp_o;
    logic [6:0] exp_a;
    int err_total = 0;
    int total_checks = 0;

    // 25 MHz core clock
    initial
    begin
        forever #20 core_clk_i = ~core_clk_i;
    end

    host_cfg_model host (.core_clk_i(core_clk_i), .host_addr_wr_o(host_wr),
        .host_addr_o(host_addr), .buf_mode_o(buf_mode), .cap_a_o(cap_a), .cap_b_o(cap_b),
        .osc_dbl_o(osc_dbl), .pll_dbl_o(pll_dbl));

    strap_osc_ctrl dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .test_strap_i(test_strap),
        .config_index_strap_i(idx_strap), .if_mode_strap_i(if_strap),
        .script_addr_wr_i(script_wr), .script_addr_i(script_addr), .host_addr_wr_i(host_wr),
        .host_addr_i(host_addr), .osc_pin_buffer_mode_i(buf_mode), .pin_a_load_cap_i(cap_a),
        .pin_b_load_cap_i(cap_b), .osc_doubler_enable_i(osc_dbl),
        .pll_input_doubler_enable_i(pll_dbl), .strap_status_reg_o(status),
        .straps_valid_o(valid), .spi_mode_o(spi), .slave_address_reg_o(addr),
        .config_index_o(cfg_idx), .autocfg_run_o(autocfg), .osc_ctrl_o(osc));

    // prints the counts and verdict, then stops
    task automatic complete_run();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // auto-config script strobe, same shape as the host write
    task automatic script_write(input logic [6:0] a);
        script_addr = a;
        script_wr = 1'b1;
        @(negedge core_clk_i);
        script_wr = 1'b0;
        script_addr = ~a;
    endtask

    // hold reset 3 cycles with the given straps, then release at a falling edge;
    // called at time zero or at a falling edge, so the hold is exactly 3 cycles
    task automatic reset_with(input logic t, input logic [2:0] i, input logic [1:0] m);
        rst_n_i = 1'b0;
        test_strap = t;
        idx_strap = i;
        if_strap = m;
        repeat (3) @(negedge core_clk_i);
        `CHK(addr, strap_osc_pkg::ADDR_RST)
        `CHK(valid, 1'b0)
        rst_n_i = 1'b1;
    endtask

    initial
    begin
        // one reset per config index 0 to 7, interface and test straps derived from it; later strap changes must stay invisible
        for (int i = 0; i < 8; i++)
        begin
            reset_with(i == 3 || i == 5, i[2:0], i[1:0]);
            if (i == 7)
                host.write_addr(7'h11); // strobe on first edge is ignored
            else
                @(negedge core_clk_i);
            exp_s = '{i == 3 || i == 5, i[2:0], i[1:0]};
            exp_a = (i[1:0] == 2'h0) ? 7'h74 : (i[1:0] == 2'h1) ? 7'h75 : 7'h76;
            `CHK(valid, 1'b1)
            `CHK(addr, exp_a)
            `CHK(spi, i[1:0] == 2'h3)
            `CHK(cfg_idx, i[2:0])
            `CHK(autocfg, i != 3)
            test_strap = ~test_strap;
            idx_strap = ~idx_strap;
            if_strap = ~if_strap;
            repeat (2) @(negedge core_clk_i);
            `CHK(status, exp_s)
        end
        // address overwrites, then both strobes together
        script_write(7'h2A);
        `CHK(addr, 7'h2A)
        host.write_addr(7'h55);
        `CHK(addr, 7'h55)
        fork
            script_write(7'h0F);
            host.write_addr(7'h70);
        join
        `CHK(addr, 7'h0F)
        // every buffer mode with and without the oscillator doubler
        for (int m = 0; m < 4; m++)
        begin
            for (int d = 0; d < 2; d++)
            begin
                // pll doubler always requested; the model must drop it with the other on
                host.set_osc(m[1:0], 5'(m * 8 + d), 5'(m * 8 + d) ^ 5'h1F, d[0], 1'b1);
                @(negedge core_clk_i);
                exp_o.xtal_drv_en = (m == 1);
                exp_o.se_in_en = (m == 2);
                exp_o.pin_a_cap = 5'(m * 8 + d);
                exp_o.pin_b_cap = 5'(m * 8 + d) ^ 5'h1F;
                exp_o.osc_x2 = d[0] && (m == 1 || m == 2);
                exp_o.pll_in_x2 = ~d[0];
                `CHK(osc, exp_o)
            end
        end
        complete_run();
    end

    // watchdog well beyond the expected run length
    initial
    begin
        #(40 * 2000);
        err_total++;
        complete_run();
    end
endmodule
